// ===== pepw_pkg.sv
package pepw_pkg;
  // ----------------------------------------
  // Memory geometry
  // ----------------------------------------
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  localparam int PAGE_LSB = 6;
  localparam int PAGE_BYTES = 64;
  localparam int COMP_BIT = 7;
  localparam int TOGG_BIT = 6;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_PS = 8000;
  localparam int LOAD_WINDOW_US = 100;
  localparam int LOAD_WINDOW_CYC = (LOAD_WINDOW_US * 1000000) / CLK_PERIOD_PS;
  localparam int GUARD_CYC = LOAD_WINDOW_CYC - 125;
  localparam int PHASE_CYC = 4;
  localparam logic [1:0] OP_READ = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_POLL = 2'h2;

  typedef struct packed {
    logic [1:0] op;
    logic last;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } pepw_req_t;

  typedef struct packed {
    logic ceN;
    logic oeN;
    logic weN;
  } pepw_strobe_t;

  typedef enum logic [2:0] {
    S_IDLE, S_SETUP, S_STROBE, S_HOLD, S_GAP, S_WAIT
  } pepw_state_t;
endpackage

// ===== pepw_host.sv
`timescale 1ns/100ps
module pepw_host
  import pepw_pkg::*;
#(
  parameter int LOAD_GUARD = GUARD_CYC
)(
  input wire logic clk,
  input wire logic sys_rst,
  input wire pepw_req_t req,
  input wire logic reqValid,
  output logic reqReady,
  output logic [DATA_W-1:0] rspData,
  output logic rspValid,
  output logic busy,
  output logic pageError,
  output logic [ADDR_W-1:0] memAddr,
  output pepw_strobe_t strobe,
  output logic [DATA_W-1:0] dataOut,
  output logic dataOe,
  input wire logic [DATA_W-1:0] dataIn
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [ADDR_W-PAGE_LSB-1:0] pageOf(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:PAGE_LSB];
  endfunction

  pepw_state_t state;
  pepw_req_t cur;
  logic [2:0] phase;
  logic [31:0] gapCnt;
  logic inPage;
  logic [6:0] loadCount;
  logic [ADDR_W-PAGE_LSB-1:0] pageAddr;
  logic [DATA_W-1:0] lastData;
  logic polling;
  logic havePrev;
  logic prevToggle;
  logic isWrite;
  logic samePage;
  logic pageFull;
  logic [31:0] settleCnt;
  // Wait from page close until the device has surely started programming
  localparam int SETTLE_CYC = LOAD_GUARD + LOAD_WINDOW_CYC - GUARD_CYC;

  assign isWrite = (req.op == OP_WRITE);
  assign samePage = pageOf(req.addr) == pageAddr;
  assign pageFull = loadCount == 7'(PAGE_BYTES);

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state <= S_IDLE;
      cur <= '0;
      phase <= 3'h0;
      gapCnt <= 32'h0;
      reqReady <= 1'b0;
    end
    else
    begin
      unique case (state)
        S_IDLE:
        begin
          // A request seen with ready high is always answered first
          if (reqValid && reqReady)
          begin
            // a foreign page or full page is refused
            if (isWrite && inPage && (!samePage || pageFull))
              state <= S_IDLE;
            else
            begin
              cur <= req;
              phase <= 3'h0;
              reqReady <= 1'b0;
              state <= S_SETUP;
            end
          end
          else if (inPage && gapCnt >= 32'(LOAD_GUARD))
          begin
            state <= S_WAIT;
            reqReady <= 1'b0;
          end
          else
            reqReady <= 1'b1;
          if (inPage)
            gapCnt <= gapCnt + 32'h1;
        end
        S_SETUP:
        begin
          if (inPage)
            gapCnt <= gapCnt + 32'h1;
          phase <= phase + 3'h1;
          if (phase == 3'(PHASE_CYC - 1))
          begin
            phase <= 3'h0;
            state <= S_STROBE;
            if (cur.op == OP_WRITE)
              gapCnt <= 32'h0;
          end
        end
        S_STROBE:
        begin
          if (inPage || cur.op == OP_WRITE)
            gapCnt <= gapCnt + 32'h1;
          phase <= phase + 3'h1;
          if (phase == 3'(PHASE_CYC - 1))
          begin
            phase <= 3'h0;
            state <= S_HOLD;
          end
        end
        S_HOLD:
        begin
          if (inPage)
            gapCnt <= gapCnt + 32'h1;
          state <= S_GAP;
        end
        S_GAP:
        begin
          if (inPage)
            gapCnt <= gapCnt + 32'h1;
          if ((cur.op == OP_WRITE && cur.last) || cur.op == OP_POLL)
            state <= S_WAIT;
          else
            state <= S_IDLE;
        end
        S_WAIT:
        begin
          gapCnt <= 32'h0;
          // settle, then poll until bit 6 stops toggling
          if (polling && (havePrev || settleCnt >= 32'(SETTLE_CYC)))
          begin
            cur.op <= OP_POLL;
            phase <= 3'h0;
            state <= S_SETUP;
          end
          else if (!polling && !inPage)
          begin
            state <= S_IDLE;
            reqReady <= 1'b1;
          end
        end
        default:
          state <= S_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Settle timer before the first poll
  // ----------------------------------------
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      settleCnt <= 32'h0;
    else if (state == S_WAIT && !havePrev)
      settleCnt <= settleCnt + 32'h1;
    else
      settleCnt <= 32'h0;
  end

  // ----------------------------------------
  // Page tracking
  // ----------------------------------------
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      inPage <= 1'b0;
      loadCount <= 7'h0;
      pageAddr <= '0;
      lastData <= '0;
      polling <= 1'b0;
      pageError <= 1'b0;
    end
    else
    begin
      pageError <= state == S_IDLE && reqValid && reqReady && isWrite && inPage && (!samePage || pageFull);
      if (state == S_STROBE && phase == 3'h0 && cur.op == OP_WRITE)
      begin
        inPage <= 1'b1;
        loadCount <= loadCount + 7'h1;
        pageAddr <= pageOf(cur.addr);
        lastData <= cur.data;
      end
      if (state == S_WAIT && !polling && inPage)
      begin
        inPage <= 1'b0;
        loadCount <= 7'h0;
        polling <= 1'b1;
      end
      else if (state == S_HOLD && cur.op == OP_POLL && havePrev && dataIn[TOGG_BIT] == prevToggle)
        polling <= 1'b0;
    end
  end

  // ----------------------------------------
  // Pin drive
  // ----------------------------------------
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      strobe <= '{ceN: 1'b1, oeN: 1'b1, weN: 1'b1};
      memAddr <= '0;
      dataOut <= '0;
      dataOe <= 1'b0;
    end
    else
    begin
      strobe <= '{ceN: 1'b1, oeN: 1'b1, weN: 1'b1};
      dataOe <= 1'b0;
      // Data held one cycle past the strobe rise
      if (state == S_HOLD && cur.op == OP_WRITE)
        dataOe <= 1'b1;
      if (state == S_SETUP || state == S_STROBE)
      begin
        memAddr <= cur.op == OP_POLL ? memAddr : cur.addr;
        strobe.ceN <= 1'b0;
        if (cur.op == OP_WRITE)
        begin
          dataOut <= cur.data;
          dataOe <= 1'b1;
          strobe.weN <= state != S_STROBE;
        end
        else
          strobe.oeN <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Read answers and status capture
  // ----------------------------------------
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rspData <= '0;
      rspValid <= 1'b0;
      havePrev <= 1'b0;
      prevToggle <= 1'b0;
      busy <= 1'b0;
    end
    else
    begin
      rspValid <= 1'b0;
      busy <= state != S_IDLE || inPage;
      // Sampled while the read strobes still stand
      if (state == S_HOLD && cur.op == OP_READ)
      begin
        rspData <= dataIn;
        rspValid <= 1'b1;
      end
      if (state == S_HOLD && cur.op == OP_POLL)
      begin
        havePrev <= 1'b1;
        prevToggle <= dataIn[TOGG_BIT];
      end
      else if (state == S_IDLE)
        havePrev <= 1'b0;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_noDualStrobe;
    @(posedge clk) disable iff (sys_rst) !(strobe.weN == 1'b0 && strobe.oeN == 1'b0);
  endproperty
  a_noDualStrobe: assert property (p_noDualStrobe) else $error("write and read strobes together");

  property p_selectOnWrite;
    @(posedge clk) disable iff (sys_rst) !strobe.weN |-> !strobe.ceN && dataOe;
  endproperty
  a_selectOnWrite: assert property (p_selectOnWrite) else $error("write strobe without select");

  property p_selectOnRead;
    @(posedge clk) disable iff (sys_rst) !strobe.oeN |-> !strobe.ceN && !dataOe;
  endproperty
  a_selectOnRead: assert property (p_selectOnRead) else $error("read gate without select");

  property p_pageLimit;
    @(posedge clk) disable iff (sys_rst) loadCount <= 7'(PAGE_BYTES);
  endproperty
  a_pageLimit: assert property (p_pageLimit) else $error("page load over 64 bytes");

  property p_pageSame;
    @(posedge clk) disable iff (sys_rst)
      $fell(strobe.weN) && inPage |-> pageOf(memAddr) == pageAddr;
  endproperty
  a_pageSame: assert property (p_pageSame) else $error("page address changed in load");

  property p_loadWindow;
    @(posedge clk) disable iff (sys_rst) gapCnt < 32'(LOAD_WINDOW_CYC);
  endproperty
  a_loadWindow: assert property (p_loadWindow) else $error("byte load window exceeded");

  property p_weStable;
    @(posedge clk) disable iff (sys_rst) $fell(strobe.weN) |-> !strobe.weN [*3];
  endproperty
  a_weStable: assert property (p_weStable) else $error("write strobe pulse too short");

  property p_dataHold;
    @(posedge clk) disable iff (sys_rst) $rose(strobe.weN) |-> dataOe;
  endproperty
  a_dataHold: assert property (p_dataHold) else $error("write data released with strobe");

  property p_noWriteWhilePolling;
    @(posedge clk) disable iff (sys_rst) polling |-> strobe.weN;
  endproperty
  a_noWriteWhilePolling: assert property (p_noWriteWhilePolling) else $error("write during programming");
endmodule

// ===== pepw_eeprom_model.sv
`timescale 1ns/100ps
module pepw_eeprom_model
  import pepw_pkg::*;
#(
  parameter int LOAD_TO = 62,
  parameter int PROG_CYC = 300
)(
  input wire logic clk,
  input wire logic [ADDR_W-1:0] memAddr,
  input wire pepw_strobe_t strobe,
  input wire logic [DATA_W-1:0] busIn,
  output logic [DATA_W-1:0] busOut,
  output logic busDrive
);
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic [DATA_W-1:0] pageBuf [0:PAGE_BYTES-1];
  logic [PAGE_BYTES-1:0] slotUsed = '0;
  logic [ADDR_W-1:0] latAddr;
  logic [ADDR_W-1:0] lastAddr;
  logic [DATA_W-1:0] lastData;
  logic loading = 1'b0;
  logic armed = 1'b0;
  logic toggle = 1'b0;
  int idle = 0;
  int progLeft = 0;
  int badCnt = 0;
  wire writeSel = !strobe.ceN && !strobe.weN && strobe.oeN;
  wire readSel = !strobe.ceN && !strobe.oeN;
  initial
  begin
    foreach (mem[i])
      mem[i] = 8'h00;
  end
  always @(posedge writeSel)
  begin
    armed = (progLeft == 0);
    if (!armed)
      badCnt++;
    if (armed && loading && memAddr[ADDR_W-1:PAGE_LSB] != lastAddr[ADDR_W-1:PAGE_LSB])
      badCnt++;
    latAddr = memAddr;
    idle = 0;
  end
  // Store byte in page slot when writeSel falls (write strobe rise)
  always @(negedge writeSel)
    if (armed)
    begin
      pageBuf[latAddr[PAGE_LSB-1:0]] = busIn;
      slotUsed[latAddr[PAGE_LSB-1:0]] = 1'b1;
      lastAddr = latAddr;
      lastData = busIn;
      loading = 1'b1;
      armed = 1'b0;
    end
  always @(posedge clk)
    if (loading)
    begin
      idle++;
      if (idle >= LOAD_TO)
      begin
        foreach (pageBuf[i])
          if (slotUsed[i])
            mem[{lastAddr[ADDR_W-1:PAGE_LSB], i[PAGE_LSB-1:0]}] = pageBuf[i];
        slotUsed = '0;
        loading = 1'b0;
        progLeft = PROG_CYC;
      end
    end
    else if (progLeft > 0)
      progLeft--;
  always @(posedge readSel)
    if (progLeft > 0)
      toggle = ~toggle;
  assign busDrive = readSel;
  assign busOut = (progLeft > 0) ? {~lastData[7], toggle, lastData[5:0]} : mem[memAddr];
endmodule

// ===== pepw_host_bench.sv
`timescale 1ns/100ps
`define CHK(a, b) begin nChecks++; if ((a) !== (b)) begin errorCnt++; $display("wrong value at %0t: %0h", $time, a); end end
module pepw_host_bench;
  import pepw_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  pepw_req_t req = '0;
  logic reqValid = 1'b0;
  logic reqReady;
  logic [DATA_W-1:0] rspData;
  logic rspValid;
  logic busy;
  logic pageError;
  logic [ADDR_W-1:0] memAddr;
  pepw_strobe_t strobe;
  logic [DATA_W-1:0] dataOut;
  logic dataOe;
  wire logic [DATA_W-1:0] dataIn;
  logic [DATA_W-1:0] busOut;
  logic busDrive;
  logic [31:0] cyc = '0;
  logic [31:0] rnd = 32'had926856;
  logic [DATA_W-1:0] refMem [int];
  int errorCnt = 0;
  int nChecks = 0;
  int pageErrs = 0;
  int clash = 0;
  pepw_host #(.LOAD_GUARD(60)) dut (.clk(clk), .sys_rst(sys_rst), .req(req), .reqValid(reqValid),
    .reqReady(reqReady), .rspData(rspData), .rspValid(rspValid), .busy(busy), .pageError(pageError),
    .memAddr(memAddr), .strobe(strobe), .dataOut(dataOut), .dataOe(dataOe), .dataIn(dataIn));
  pepw_eeprom_model #(.LOAD_TO(62), .PROG_CYC(300)) em (.clk(clk), .memAddr(memAddr), .strobe(strobe),
    .busIn(dataIn), .busOut(busOut), .busDrive(busDrive));
  // Undriven bus shows a changing pattern
  assign dataIn = dataOe ? dataOut : (busDrive ? busOut : ~cyc[7:0]);
  always #4 clk = ~clk;
  task automatic complete_run;
    $display("checks %0d errors %0d", nChecks, errorCnt);
    if (errorCnt == 0 && nChecks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 32'h1;
    if (pageError === 1'b1)
      pageErrs++;
    if (dataOe === 1'b1 && busDrive === 1'b1)
      clash++;
    if (cyc == 32'h4e20)
    begin
      errorCnt++;
      complete_run();
    end
  end
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [DATA_W-1:0] refGet(int a);
    return refMem.exists(a) ? refMem[a] : 8'h00;
  endfunction
  task automatic send(logic [1:0] op, logic lst, logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
    @(posedge clk);
    req <= '{op, lst, a, d};
    reqValid <= 1'b1;
    do @(posedge clk); while (reqReady !== 1'b1);
    reqValid <= 1'b0;
  endtask
  task automatic rd(logic [ADDR_W-1:0] a);
    send(OP_READ, 1'b0, a, 8'h00);
    do @(posedge clk); while (rspValid !== 1'b1);
    `CHK(rspData, refGet(int'(a)))
  endtask
  task automatic waitIdle;
    @(posedge clk);
    do @(posedge clk); while (busy !== 1'b0);
    `CHK(em.progLeft == 0 && !em.loading, 1'b1)
  endtask
  initial
  begin
    logic [6:0] pg;
    logic [ADDR_W-1:0] a;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    pg = rnd[6:0];
    // Full page in scrambled slot order, then two refusals
    for (int i = 0; i < PAGE_BYTES; i++)
    begin
      rnd = lfsr(rnd);
      a = {pg, 6'((i * 37) % PAGE_BYTES)};
      refMem[a] = rnd[7:0];
      send(OP_WRITE, 1'b0, a, rnd[7:0]);
    end
    send(OP_WRITE, 1'b0, {pg, 6'h05}, 8'h5a);
    send(OP_WRITE, 1'b0, {pg + 7'h1, 6'h05}, 8'ha5);
    waitIdle();
    `CHK(pageErrs, 2)
    for (int i = 0; i < PAGE_BYTES; i++)
      rd({pg, 6'(i)});
    // Short pages of one to four bytes closed by last
    for (int k = 1; k <= 4; k++)
    begin
      rnd = lfsr(rnd);
      a = (k == 4) ? 13'h1fc0 : rnd[12:0];
      for (int j = 0; j < k; j++)
      begin
        refMem[a ^ 13'(j)] = rnd[7:0] ^ 8'(j);
        send(OP_WRITE, 1'(j == k - 1), a ^ 13'(j), rnd[7:0] ^ 8'(j));
      end
      waitIdle();
      for (int j = 0; j < k; j++)
        rd(a ^ 13'(j));
      rd(a ^ 13'h0040);
    end
    `CHK(em.badCnt, 0)
    `CHK(clash, 0)
    complete_run();
  end
endmodule
